// ### common/iobsel_map.svh
`ifndef IOBSEL_MAP_SVH
`define IOBSEL_MAP_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define IOBSEL_CODE_W 6
`define IOBSEL_RX_W 15
`define IOBSEL_DIN_W 12
`define IOBSEL_NPULSE 3
`define IOBSEL_CNT_W 8

// ----------------------------------------
// timing
// ----------------------------------------
`define IOBSEL_CLK_MHZ 100
`define IOBSEL_INIT_NS 600
`define IOBSEL_PULSE_NS 100
`define IOBSEL_SETTLE_NS 200
`define IOBSEL_GAP_NS 200
`define IOBSEL_MATCH_WAIT_CYC 16
// two synchroniser flops plus one edge of margin
`define IOBSEL_SYNC_CYC 3
`define IOBSEL_INIT_CYC ((`IOBSEL_INIT_NS * `IOBSEL_CLK_MHZ + 999) / 1000)
`define IOBSEL_PULSE_CYC ((`IOBSEL_PULSE_NS * `IOBSEL_CLK_MHZ + 999) / 1000)
`define IOBSEL_SETTLE_CYC ((`IOBSEL_SETTLE_NS * `IOBSEL_CLK_MHZ + 999) / 1000)
`define IOBSEL_GAP_CYC ((`IOBSEL_GAP_NS * `IOBSEL_CLK_MHZ + 999) / 1000)

`endif

// ### common/iobsel_pkg.sv
package iobsel_pkg;
	typedef enum logic [2:0] {
		ST_INIT,
		ST_IDLE,
		ST_ADDR,
		ST_SETTLE,
		ST_NEXT,
		ST_PULSE,
		ST_GAP,
		ST_DONE
	} iobsel_state_t;
endpackage : iobsel_pkg

// ### common/iobsel_pin_if.sv
`timescale 1ns/1ps
`include "iobsel_map.svh"
interface iobsel_pin_if;
	logic match;
	logic [`IOBSEL_RX_W-1:0] rx_data;
	logic [`IOBSEL_DIN_W-1:0] din;
	modport src (output match, output rx_data, output din);
	modport sink (input match, input rx_data, input din);
endinterface : iobsel_pin_if

// ### rtl/iobsel_sync.sv
`timescale 1ns/1ps
`include "iobsel_map.svh"
module iobsel_sync (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic pin_match,
	input wire logic [`IOBSEL_RX_W-1:0] pin_rx_data,
	input wire logic [`IOBSEL_DIN_W-1:0] pin_din,
	iobsel_pin_if.src pins
);
	// ----------------------------------------
	// two-flop synchronisers
	// ----------------------------------------
	logic [`IOBSEL_RX_W+`IOBSEL_DIN_W:0] meta_r;
	logic [`IOBSEL_RX_W+`IOBSEL_DIN_W:0] sync_r;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= {pin_match, pin_rx_data, pin_din};
			sync_r <= meta_r;
		end
	end

	assign pins.match = sync_r[`IOBSEL_RX_W+`IOBSEL_DIN_W];
	assign pins.rx_data = sync_r[`IOBSEL_RX_W+`IOBSEL_DIN_W-1:`IOBSEL_DIN_W];
	assign pins.din = sync_r[`IOBSEL_DIN_W-1:0];
endmodule : iobsel_sync

// ### rtl/iobsel_host.sv
`timescale 1ns/1ps
`include "iobsel_map.svh"
module iobsel_host (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic start_key,
	input wire logic req_valid,
	input wire logic [`IOBSEL_CODE_W-1:0] req_code,
	input wire logic [`IOBSEL_NPULSE-1:0] req_pulse_mask,
	input wire logic [`IOBSEL_DIN_W-1:0] req_wdata,
	output logic req_ready,
	output logic resp_valid,
	output logic resp_selected,
	output logic [`IOBSEL_RX_W-1:0] resp_rx_data,
	output logic [`IOBSEL_DIN_W-1:0] resp_din,
	output logic bus_init,
	output logic [`IOBSEL_CODE_W-1:0] code_true_n,
	output logic [`IOBSEL_CODE_W-1:0] code_comp_n,
	output logic [`IOBSEL_NPULSE-1:0] io_timing_pulse,
	output logic [`IOBSEL_DIN_W-1:0] memory_buffer_lines,
	output logic rx_enable,
	input wire logic dev_match,
	input wire logic [`IOBSEL_RX_W-1:0] rx_data,
	input wire logic [`IOBSEL_DIN_W-1:0] data_in_lines
);
	localparam logic [`IOBSEL_CNT_W-1:0] INIT_LAST = `IOBSEL_CNT_W'(`IOBSEL_INIT_CYC - 1);
	localparam logic [`IOBSEL_CNT_W-1:0] PULSE_LAST = `IOBSEL_CNT_W'(`IOBSEL_PULSE_CYC - 1);
	// pins reach logic late, so the settle window is stretched by the synchroniser
	localparam logic [`IOBSEL_CNT_W-1:0] SETTLE_LAST = `IOBSEL_CNT_W'(`IOBSEL_SETTLE_CYC + `IOBSEL_SYNC_CYC - 1);
	localparam logic [`IOBSEL_CNT_W-1:0] GAP_LAST = `IOBSEL_CNT_W'(`IOBSEL_GAP_CYC - 1);
	localparam logic [`IOBSEL_CNT_W-1:0] WAIT_LAST = `IOBSEL_CNT_W'(`IOBSEL_MATCH_WAIT_CYC - 1);
	localparam logic [`IOBSEL_CNT_W-1:0] MATCH_TRUST = `IOBSEL_CNT_W'(`IOBSEL_MATCH_WAIT_CYC - `IOBSEL_SYNC_CYC);
	localparam logic [1:0] IDX_END = 2'h3;

	iobsel_pin_if pins ();
	iobsel_pkg::iobsel_state_t state_r;
	logic [`IOBSEL_CNT_W-1:0] cnt_r;
	logic [1:0] idx_r;
	logic [`IOBSEL_NPULSE-1:0] mask_r;
	logic match_ok;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	iobsel_sync u_sync (
		.clock(clock),
		.reset_n(reset_n),
		.pin_match(dev_match),
		.pin_rx_data(rx_data),
		.pin_din(data_in_lines),
		.pins(pins)
	);

	// a match from the last transfer may still sit in the synchroniser
	assign match_ok = pins.match && (cnt_r <= MATCH_TRUST);

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_r <= iobsel_pkg::ST_INIT;
			cnt_r <= INIT_LAST;
			idx_r <= 2'h0;
			mask_r <= '0;
			bus_init <= 1'b1; // power-up init
			req_ready <= 1'b0;
			code_true_n <= '1;
			code_comp_n <= '1;
			io_timing_pulse <= '0;
			memory_buffer_lines <= '0;
			rx_enable <= 1'b0;
		end else begin
			case (state_r)
				iobsel_pkg::ST_INIT: begin
					if (cnt_r == '0) begin
						bus_init <= 1'b0;
						req_ready <= 1'b1;
						state_r <= iobsel_pkg::ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				iobsel_pkg::ST_IDLE: begin
					if (start_key) begin
						bus_init <= 1'b1; // start control re-inits
						req_ready <= 1'b0;
						cnt_r <= INIT_LAST;
						state_r <= iobsel_pkg::ST_INIT;
					end else if (req_valid) begin
						code_true_n <= ~req_code; // asserted pair line is ground
						code_comp_n <= req_code;
						mask_r <= req_pulse_mask;
						memory_buffer_lines <= req_wdata;
						req_ready <= 1'b0;
						idx_r <= 2'h0;
						cnt_r <= WAIT_LAST;
						state_r <= iobsel_pkg::ST_ADDR;
					end
				end
				iobsel_pkg::ST_ADDR: begin
					if (match_ok) begin
						rx_enable <= 1'b1; // enable only once addressed
						cnt_r <= SETTLE_LAST;
						state_r <= iobsel_pkg::ST_SETTLE;
					end else if (cnt_r == '0) begin
						state_r <= iobsel_pkg::ST_DONE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				iobsel_pkg::ST_SETTLE: begin
					// receivers indeterminate until this runs out
					if (cnt_r == '0) begin
						state_r <= iobsel_pkg::ST_NEXT;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				iobsel_pkg::ST_NEXT: begin
					if (idx_r == IDX_END) begin
						state_r <= iobsel_pkg::ST_DONE;
					end else if (mask_r[idx_r]) begin
						io_timing_pulse[idx_r] <= 1'b1; // one pulse at a time
						cnt_r <= PULSE_LAST;
						state_r <= iobsel_pkg::ST_PULSE;
					end else begin
						idx_r <= idx_r + 1'b1;
					end
				end
				iobsel_pkg::ST_PULSE: begin
					if (cnt_r == '0) begin
						io_timing_pulse <= '0;
						cnt_r <= GAP_LAST;
						state_r <= iobsel_pkg::ST_GAP;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				iobsel_pkg::ST_GAP: begin
					// gap lets the peripheral drive its input data back
					if (cnt_r == '0) begin
						idx_r <= idx_r + 1'b1;
						state_r <= iobsel_pkg::ST_NEXT;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: begin
					code_true_n <= '1;
					code_comp_n <= '1;
					io_timing_pulse <= '0;
					memory_buffer_lines <= '0;
					rx_enable <= 1'b0;
					req_ready <= 1'b1;
					idx_r <= 2'h0;
					state_r <= iobsel_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// response capture
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			resp_valid <= 1'b0;
			resp_selected <= 1'b0;
			resp_rx_data <= '0;
			resp_din <= '0;
		end else begin
			resp_valid <= (state_r == iobsel_pkg::ST_DONE);
			if (state_r == iobsel_pkg::ST_IDLE && req_valid && !start_key) begin
				resp_selected <= 1'b0;
			end else if (state_r == iobsel_pkg::ST_ADDR && match_ok) begin
				resp_selected <= 1'b1;
			end
			// sampled by time, not by the enable edge
			if (state_r == iobsel_pkg::ST_SETTLE && cnt_r == '0) begin
				resp_rx_data <= pins.rx_data;
			end
			if (state_r == iobsel_pkg::ST_DONE) begin
				resp_din <= resp_selected ? pins.din : '0; // accumulator input
			end
		end
	end
endmodule : iobsel_host

// ### sim/iobsel_host_assertions.sv
`timescale 1ns/1ps
module iobsel_host_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic start_key,
	input wire logic req_ready,
	input wire logic resp_valid,
	input wire logic bus_init,
	input wire logic [5:0] code_true_n,
	input wire logic [5:0] code_comp_n,
	input wire logic [2:0] io_timing_pulse,
	input wire logic [11:0] memory_buffer_lines,
	input wire logic rx_enable,
	input wire logic [14:0] resp_rx_data
);
	// ----
	// bus rules
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_pon; $rose(|io_timing_pulse); endsequence
	sequence s_pbody; (|io_timing_pulse)[*8] ##1 (|io_timing_pulse)[*2] ##1 !(|io_timing_pulse); endsequence
	// init end also raises ready, so only a transfer end counts
	sequence s_done; $rose(req_ready) && !$past(bus_init); endsequence
	a_pulse_ten_wide: assert property (s_pon |-> s_pbody) else $error("pulse width");
	a_pulse_needs_en: assert property (|io_timing_pulse |-> rx_enable) else $error("pulse unselected");
	a_start_inits: assert property (start_key && req_ready |=> bus_init[*8]) else $error("no init");
	a_done_resp: assert property (s_done |-> resp_valid) else $error("no response");
	a_code_pairs: assert property (!req_ready && !bus_init |-> (code_true_n ^ code_comp_n) == 6'h3f)
		else $error("pair not complementary");
	a_idle_free: assert property (req_ready |-> &(code_true_n & code_comp_n) && memory_buffer_lines == 12'h0
		&& !rx_enable) else $error("idle lines driven");
	a_settle_rx: assert property ($rose(rx_enable) |=> $stable(resp_rx_data)[*8] ##1 $stable(resp_rx_data)[*8]
		##1 $stable(resp_rx_data)[*6]) else $error("early sample");
endmodule : iobsel_host_chk

// ### sim/iobsel_periph.sv
`timescale 1ns/1ps
module iobsel_periph #(
	parameter logic [5:0] DEV_CODE = 6'h2a,
	parameter logic [11:0] DIN_VAL = 12'h5c3
) (
	input wire logic bus_init,
	input wire logic override,
	input wire logic [5:0] code_true_n,
	input wire logic [5:0] code_comp_n,
	input wire logic [2:0] io_timing_pulse,
	input wire logic [11:0] memory_buffer_lines,
	input wire logic rx_enable,
	output logic dev_match,
	output logic [2:0] gated_pulse,
	output logic [2:0] gated_pulse_n,
	output logic [14:0] rx_data,
	output logic [11:0] data_in_lines
);
	logic settled = 1'b0;
	// ----
	// decoder, gates, receivers
	// ----
	// each bit is wired to the line of its pair that is low for this code
	assign dev_match = override | ~|((code_true_n & DEV_CODE) | (code_comp_n & ~DEV_CODE));
	assign gated_pulse = io_timing_pulse & {3{dev_match}};
	assign gated_pulse_n = ~gated_pulse;
	// unsettled receivers show the inverse, so an early sample cannot pass
	assign rx_data = !rx_enable ? 15'h0 : {3'h0, memory_buffer_lines ^ {12{~settled}}};
	assign data_in_lines = dev_match ? DIN_VAL : 12'h000;
	always @(posedge rx_enable) begin
		settled = 1'b0;
		#200;
		settled = rx_enable;
	end
	always @(negedge rx_enable or posedge bus_init) settled = 1'b0;
endmodule : iobsel_periph

// ### sim/test_iobsel_host.sv
`timescale 1ns/1ps
module test_iobsel_host;
	typedef struct {logic [5:0] c; logic [2:0] m; logic [11:0] w; logic o; logic s; logic [1:0] np;} iobsel_row_t;
	logic clock = 1'b0, reset_n = 1'b0, start_key = 1'b0, req_valid = 1'b0, ovr = 1'b0;
	logic [5:0] req_code = 6'h00, code_true_n, code_comp_n;
	logic [2:0] req_pulse_mask = 3'h0, io_timing_pulse, gp, gp_q = 3'h0;
	logic [11:0] req_wdata = 12'h000, resp_din, memory_buffer_lines, data_in_lines;
	logic req_ready, resp_valid, resp_selected, bus_init, rx_enable, dev_match;
	logic [14:0] resp_rx_data, rx_data;
	int errors = 0, num_checks = 0, pulses = 0, n;
	iobsel_row_t rows [5] = '{'{6'h2a, 3'h7, 12'ha5a, 1'b0, 1'b1, 2'h3}, '{6'h2a, 3'h0, 12'h0ff, 1'b0, 1'b1, 2'h0},
		'{6'h2b, 3'h5, 12'h123, 1'b0, 1'b0, 2'h0}, '{6'h0a, 3'h7, 12'h321, 1'b0, 1'b0, 2'h0},
		'{6'h15, 3'h2, 12'hfff, 1'b1, 1'b1, 2'h1}};
	iobsel_host i_iobsel_host (.clock, .reset_n, .start_key, .req_valid, .req_code, .req_pulse_mask, .req_wdata,
		.req_ready, .resp_valid, .resp_selected, .resp_rx_data, .resp_din, .bus_init, .code_true_n, .code_comp_n,
		.io_timing_pulse, .memory_buffer_lines, .rx_enable, .dev_match, .rx_data, .data_in_lines);
	iobsel_periph i_iobsel_periph (.bus_init, .override(ovr), .code_true_n, .code_comp_n, .io_timing_pulse,
		.memory_buffer_lines, .rx_enable, .dev_match, .gated_pulse(gp), .gated_pulse_n(), .rx_data, .data_in_lines);
	always #5 clock = ~clock;
	always @(posedge clock) begin
		gp_q <= gp;
		pulses <= pulses + $countones(gp & ~gp_q);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		if (errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic tick();
		@(posedge clock);
		#1;
	endtask : tick
	// 0 ready, 1 response, 2 init over; n ends as the cycles waited
	task automatic wait_on(input int w, input int bound);
		n = 0;
		while (!(w == 0 ? req_ready === 1'b1 : w == 1 ? resp_valid === 1'b1 : bus_init === 1'b0)) begin
			if (n == bound) begin
				errors++;
				end_sim();
			end
			tick();
			n++;
		end
	endtask : wait_on
	task automatic xfer(input iobsel_row_t r);
		wait_on(0, 200);
		{req_code, req_pulse_mask, req_wdata, ovr, req_valid} = {r.c, r.m, r.w, r.o, 1'b1};
		tick();
		req_valid = 1'b0;
		pulses = 0;
		wait_on(1, 600);
		chk(32'(resp_selected), 32'(r.s));
		chk(32'(pulses), 32'(r.np));
		chk(32'(resp_din), r.s ? 32'h5c3 : 32'h0);
		if (r.s) chk(32'(resp_rx_data), 32'(r.w));
		ovr = 1'b0;
		tick();
	endtask : xfer
	initial begin
		repeat (3) tick();
		reset_n = 1'b1;
		wait_on(2, 100);
		foreach (rows[i]) xfer(rows[i]);
		// start key and a request together: the key wins
		wait_on(0, 200);
		{start_key, req_valid, req_code} = {2'b11, 6'h2a};
		tick();
		{start_key, req_valid} = 2'b00;
		chk(32'({bus_init, req_ready}), 32'h2);
		wait_on(2, 100);
		chk(32'(n), 32'h3c);
		xfer(rows[0]);
		reset_n = 1'b0;
		tick();
		tick();
		chk(32'({bus_init, req_ready, code_true_n}), 32'hbf);
		reset_n = 1'b1;
		wait_on(2, 100);
		xfer(rows[4]);
		end_sim();
	end
endmodule : test_iobsel_host
bind iobsel_host iobsel_host_chk i_iobsel_host_chk (.clock, .reset_n, .start_key, .req_ready, .resp_valid,
	.bus_init, .code_true_n, .code_comp_n, .io_timing_pulse, .memory_buffer_lines, .rx_enable, .resp_rx_data);
